// >>> dtm_consts.svh
// Offsets, field widths, reset values and limits of the trigger, mask and shift control
`ifndef DTM_CONSTS_SVH
`define DTM_CONSTS_SVH
`define DTM_ADDR_TRIG      12'h000
`define DTM_ADDR_SOFT      12'h004
`define DTM_ADDR_MASK      12'h008
`define DTM_ADDR_DEPTH     12'h00c
`define DTM_ADDR_DLY_SEL   12'h010
`define DTM_ADDR_DLY_VAL   12'h014
`define DTM_ADDR_CTRL      12'h018
`define DTM_ADDR_STATUS    12'h01c
`define DTM_ADDR_REV       12'h020
`define DTM_MASK_W         24
`define DTM_MASK_RST       24'hffffff
`define DTM_DEPTH_MIN      5'h01
`define DTM_DEPTH_MAX      5'h18
`define DTM_DEPTH_RST      5'h08
`define DTM_DLY_W          11
`define DTM_DLY_MAX        11'h732
`define DTM_DLY_LINES      3
`define DTM_REV_RST        4'h9
`define DTM_SRC_MAX_LS     3'h3
`define DTM_SRC_MAX_HS     3'h4
`define DTM_SOFT_RST_DIG   1'b0
`endif

// >>> dtm_pkg.sv
// Types shared by the trigger, mask and shift control
package dtm_pkg;
  typedef enum logic [1:0] {DTM_IDLE, DTM_ARMED, DTM_RUN} dtm_state_type;
  typedef logic [23:0] dtm_word_type;
endpackage

// >>> dtm_ctrl.sv
// Trigger select, keep mask, shift depth and delay setting control with APB slave
`timescale 1ns/10ps
`include "dtm_consts.svh"
// How it works
// - Rev five to eight: soft, front high, zero, one low
// - Rev nine low speed: one high, backplane
// - Rev nine high speed: zero, one low, backplane
// - Rev nine: code0 soft, code1 front high
// - Trigger source switches with clock source
// - Open external trigger pin reads high
// - Writing one issues soft trigger, readable
// - Digital module soft trigger inactive after reset
// - Trigger starts capture and stimulus clocks
// - Memory write data masked before storing
// - Memory read data masked before leaving
// - Mask acts in both modes
// - Mask one passes, zero clears bit
// - Shift depth 1 to 24, default 8
// - Only depth stages used when shifting
// - Delay selector: capture, stimulus, connector clock
// - Delay zero to max, 10 ps steps
// - Delay query returns programmed value
// - Rev one to four: front low active
// - Measurement waits for trigger, then runs
module dtm_ctrl (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rstn,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic                       pready,
  output logic                       pslverr,
  output logic [31:0]                prdata,
  // Trigger pins, asynchronous
  input  wire logic                  front_trigger_in,
  input  wire logic                  connector_trigger_zero,
  input  wire logic                  connector_trigger_one,
  input  wire logic                  backplane_trigger,
  // Memory data path
  input  wire dtm_pkg::dtm_word_type mem_wr_data_in,
  output dtm_pkg::dtm_word_type      mem_wr_data_out,
  input  wire dtm_pkg::dtm_word_type mem_rd_data_in,
  output dtm_pkg::dtm_word_type      mem_rd_data_out,
  // Serial shifter
  input  wire logic                  shift_in_bit,
  input  wire logic                  shift_step,
  output logic                       shift_out_bit,
  output dtm_pkg::dtm_word_type      shift_word,
  // Clock run controls and delay lines
  output logic                       capture_clk_run,
  output logic                       stimulus_clk_run,
  output logic [10:0]                delay_capture,
  output logic [10:0]                delay_stimulus,
  output logic [10:0]                delay_connector,
  output logic [2:0]                 clock_source_select
);
  import dtm_pkg::*;

  // Configuration registers
  logic [2:0]          trigger_source_select_r;
  logic [2:0]          trig_pending_r;
  logic [2:0]          clk_pending_r;
  logic                soft_trigger_issue_r;
  dtm_word_type        data_keep_mask_r;
  logic [4:0]          shift_depth_r;
  logic [1:0]          dly_sel_r;
  logic [10:0]         dly_r [0:2];
  logic                high_speed_r;
  logic                pol_low_r;
  logic [3:0]          revision_r;
  logic                meas_mode_r;
  logic                commit_r;
  dtm_state_type       state_r;
  logic [2:0]          trig_s1_r;
  logic [2:0]          trig_s2_r;
  logic                bp_s1_r;
  logic                bp_s2_r;
  logic                trig_hit;
  logic                wr_en;
  logic                rd_en;
  logic [31:0]         rd_nxt;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;

  // Pin synchronisers; pull-up at the pin makes an open input read high
  always_ff @(posedge clk) begin
    if (!rstn) begin
      trig_s1_r <= 3'h7;
      trig_s2_r <= 3'h7;
      bp_s1_r   <= 1'b0;
      bp_s2_r   <= 1'b0;
    end else begin
      trig_s1_r <= {connector_trigger_one, connector_trigger_zero, front_trigger_in};
      trig_s2_r <= trig_s1_r;
      bp_s1_r   <= backplane_trigger;
      bp_s2_r   <= bp_s1_r;
    end
  end

  // Trigger source decode by revision and speed mode
  always_comb begin
    trig_hit = 1'b0;
    if (trigger_source_select_r == 3'h0) begin
      trig_hit = soft_trigger_issue_r;
    end else if (trigger_source_select_r == 3'h1) begin
      if (revision_r <= 4'h4) begin
        trig_hit = !trig_s2_r[0];
      end else begin
        trig_hit = trig_s2_r[0];
      end
    end else if (revision_r >= 4'h9 && !high_speed_r) begin
      if (trigger_source_select_r == 3'h2) begin
        trig_hit = trig_s2_r[2];
      end else if (trigger_source_select_r == 3'h3) begin
        trig_hit = bp_s2_r ^ pol_low_r;
      end
    end else begin
      if (trigger_source_select_r == 3'h2) begin
        trig_hit = trig_s2_r[1];
      end else if (trigger_source_select_r == 3'h3) begin
        trig_hit = !trig_s2_r[2];
      end else if (trigger_source_select_r == 3'h4 && revision_r >= 4'h9) begin
        trig_hit = bp_s2_r ^ pol_low_r;
      end
    end
  end

  // Pending selections, committed together
  always_ff @(posedge clk) begin
    if (!rstn) begin
      trig_pending_r <= 3'h0;
      clk_pending_r  <= 3'h0;
      commit_r       <= 1'b0;
    end else begin
      commit_r <= 1'b0;
      if (wr_en && paddr == `DTM_ADDR_TRIG) begin
        trig_pending_r <= pwdata[2:0];
        clk_pending_r  <= pwdata[10:8];
        commit_r       <= 1'b1;
      end
    end
  end

  // Trigger and clock source switched in one edge
  always_ff @(posedge clk) begin
    if (!rstn) begin
      trigger_source_select_r <= 3'h0;
      clock_source_select     <= 3'h0;
    end else if (commit_r) begin
      trigger_source_select_r <= trig_pending_r;
      clock_source_select     <= clk_pending_r;
    end
  end

  // Software trigger, keep mask, depth, delays, control
  always_ff @(posedge clk) begin
    if (!rstn) begin
      soft_trigger_issue_r <= `DTM_SOFT_RST_DIG;
      data_keep_mask_r     <= `DTM_MASK_RST;
      shift_depth_r        <= `DTM_DEPTH_RST;
      dly_sel_r            <= 2'h0;
      for (int i = 0; i < `DTM_DLY_LINES; i++) begin
        dly_r[i] <= 11'h000;
      end
      high_speed_r <= 1'b0;
      pol_low_r    <= 1'b0;
      meas_mode_r  <= 1'b0;
      revision_r   <= `DTM_REV_RST;
    end else if (wr_en) begin
      if (paddr == `DTM_ADDR_SOFT) begin
        soft_trigger_issue_r <= pwdata[0];
      end else if (paddr == `DTM_ADDR_MASK) begin
        data_keep_mask_r <= pwdata[23:0];
      end else if (paddr == `DTM_ADDR_DEPTH) begin
        if (pwdata[4:0] >= `DTM_DEPTH_MIN && pwdata[4:0] <= `DTM_DEPTH_MAX && pwdata[31:5] == 27'h0) begin
          shift_depth_r <= pwdata[4:0];
        end
      end else if (paddr == `DTM_ADDR_DLY_SEL) begin
        if (pwdata[1:0] <= 2'h2) begin
          dly_sel_r <= pwdata[1:0];
        end
      end else if (paddr == `DTM_ADDR_DLY_VAL) begin
        if (pwdata[10:0] <= `DTM_DLY_MAX && pwdata[31:11] == 21'h0) begin
          dly_r[dly_sel_r] <= pwdata[10:0];
        end
      end else if (paddr == `DTM_ADDR_CTRL) begin
        meas_mode_r  <= pwdata[0];
        high_speed_r <= pwdata[1];
        pol_low_r    <= pwdata[2];
      end else if (paddr == `DTM_ADDR_REV) begin
        revision_r <= pwdata[3:0];
      end
    end
  end

  // Measurement sequence: arm, wait for trigger, run clocks
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_r <= DTM_IDLE;
    end else begin
      case (state_r)
        DTM_IDLE: begin
          if (meas_mode_r) begin
            state_r <= DTM_ARMED;
          end
        end
        DTM_ARMED: begin
          if (!meas_mode_r) begin
            state_r <= DTM_IDLE;
          end else if (trig_hit) begin
            state_r <= DTM_RUN;
          end
        end
        DTM_RUN: begin
          if (!meas_mode_r) begin
            state_r <= DTM_IDLE;
          end
        end
        default: begin
          state_r <= DTM_IDLE;
        end
      endcase
    end
  end

  // Clock run outputs follow the run state
  always_ff @(posedge clk) begin
    if (!rstn) begin
      capture_clk_run  <= 1'b0;
      stimulus_clk_run <= 1'b0;
    end else begin
      capture_clk_run  <= (state_r == DTM_RUN);
      stimulus_clk_run <= (state_r == DTM_RUN);
    end
  end

  // Delay line outputs and readback
  always_ff @(posedge clk) begin
    if (!rstn) begin
      delay_capture   <= 11'h000;
      delay_stimulus  <= 11'h000;
      delay_connector <= 11'h000;
    end else begin
      delay_capture   <= dly_r[0];
      delay_stimulus  <= dly_r[1];
      delay_connector <= dly_r[2];
    end
  end

  // Masked memory data path, registered outputs
  always_ff @(posedge clk) begin
    if (!rstn) begin
      mem_wr_data_out <= 24'h000000;
      mem_rd_data_out <= 24'h000000;
    end else begin
      mem_wr_data_out <= mem_wr_data_in & data_keep_mask_r;
      mem_rd_data_out <= mem_rd_data_in & data_keep_mask_r;
    end
  end

  // Serial shifter limited to depth stages
  always_ff @(posedge clk) begin
    if (!rstn) begin
      shift_word <= 24'h000000;
    end else if (shift_step) begin
      for (int i = 0; i < `DTM_MASK_W; i++) begin
        if (i == 0) begin
          shift_word[i] <= shift_in_bit;
        end else if (i < shift_depth_r) begin
          shift_word[i] <= shift_word[i-1];
        end else begin
          shift_word[i] <= 1'b0;
        end
      end
    end
  end

  // Serial output stage, registered so the pin comes from a flop
  always_ff @(posedge clk) begin
    if (!rstn) begin
      shift_out_bit <= 1'b0;
    end else begin
      shift_out_bit <= shift_word[shift_depth_r - 5'h01];
    end
  end

  // Read mux
  always_comb begin
    rd_nxt = 32'h00000000;
    if (paddr == `DTM_ADDR_TRIG) begin
      rd_nxt = {21'h0, clock_source_select, 5'h0, trigger_source_select_r};
    end else if (paddr == `DTM_ADDR_SOFT) begin
      rd_nxt = {31'h0, soft_trigger_issue_r};
    end else if (paddr == `DTM_ADDR_MASK) begin
      rd_nxt = {8'h0, data_keep_mask_r};
    end else if (paddr == `DTM_ADDR_DEPTH) begin
      rd_nxt = {27'h0, shift_depth_r};
    end else if (paddr == `DTM_ADDR_DLY_SEL) begin
      rd_nxt = {30'h0, dly_sel_r};
    end else if (paddr == `DTM_ADDR_DLY_VAL) begin
      rd_nxt = {21'h0, dly_r[dly_sel_r]};
    end else if (paddr == `DTM_ADDR_CTRL) begin
      rd_nxt = {29'h0, pol_low_r, high_speed_r, meas_mode_r};
    end else if (paddr == `DTM_ADDR_STATUS) begin
      rd_nxt = {28'h0, trig_hit, 1'b0, state_r};
    end else if (paddr == `DTM_ADDR_REV) begin
      rd_nxt = {28'h0, revision_r};
    end
  end

  // APB answer: access phase ends the cycle after it starts
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        prdata  <= rd_nxt;
        pslverr <= (paddr > `DTM_ADDR_REV) || (paddr[1:0] != 2'h0);
      end
    end
  end

  // Checks
  a_mask_write: assert property (@(posedge clk) disable iff (!rstn)
    1'b1 |=> mem_wr_data_out == ($past(mem_wr_data_in) & $past(data_keep_mask_r)))
    else $error("masked write data wrong");
  a_mask_read: assert property (@(posedge clk) disable iff (!rstn)
    1'b1 |=> mem_rd_data_out == ($past(mem_rd_data_in) & $past(data_keep_mask_r)))
    else $error("masked read data wrong");
  a_depth_range: assert property (@(posedge clk) disable iff (!rstn)
    shift_depth_r >= `DTM_DEPTH_MIN && shift_depth_r <= `DTM_DEPTH_MAX)
    else $error("shift depth out of range");
  a_src_clk_together: assert property (@(posedge clk) disable iff (!rstn)
    $changed(trigger_source_select_r) |-> $past(commit_r))
    else $error("trigger source moved alone");
  a_clk_src_commit: assert property (@(posedge clk) disable iff (!rstn)
    $changed(clock_source_select) |-> $past(commit_r))
    else $error("clock source moved alone");
  a_run_after_trig: assert property (@(posedge clk) disable iff (!rstn)
    state_r == DTM_ARMED && trig_hit && meas_mode_r |=> state_r == DTM_RUN ##1 capture_clk_run)
    else $error("trigger did not start clocks");
  a_no_run_idle: assert property (@(posedge clk) disable iff (!rstn)
    state_r == DTM_IDLE |=> !capture_clk_run && !stimulus_clk_run)
    else $error("clocks run without trigger");
  a_delay_max: assert property (@(posedge clk) disable iff (!rstn)
    delay_capture <= `DTM_DLY_MAX && delay_stimulus <= `DTM_DLY_MAX && delay_connector <= `DTM_DLY_MAX)
    else $error("delay above maximum");
  a_soft_trig: assert property (@(posedge clk) disable iff (!rstn)
    wr_en && paddr == `DTM_ADDR_SOFT |=> soft_trigger_issue_r == $past(pwdata[0]))
    else $error("soft trigger not stored");
  a_shift_tail_zero: assert property (@(posedge clk) disable iff (!rstn)
    shift_step |=> (shift_word >> $past(shift_depth_r)) == 24'h000000)
    else $error("stage beyond depth not cleared");
  a_apb_ready: assert property (@(posedge clk) disable iff (!rstn)
    psel && !penable |=> pready)
    else $error("apb answer late");
  a_pready_pulse: assert property (@(posedge clk) disable iff (!rstn)
    pready |=> !pready)
    else $error("apb answer held too long");
endmodule

// >>> dtm_trig_model.sv
// Trigger sources driving the block's trigger pins
`timescale 1ns/10ps
module dtm_trig_model (
  // Clock
  input  wire logic       clk,
  // Levels requested by the bench
  input  wire logic [3:0] lvl,
  input  wire logic       front_open,
  // Trigger pins
  output logic            front_trigger_in,
  output logic            connector_trigger_zero,
  output logic            connector_trigger_one,
  output logic            backplane_trigger
);
  // Pins move after an edge; an open front pin floats high via its pull-up
  always_ff @(posedge clk) begin
    front_trigger_in       <= front_open ? 1'b1 : lvl[0];
    connector_trigger_zero <= lvl[1];
    connector_trigger_one  <= lvl[2];
    backplane_trigger      <= lvl[3];
  end
endmodule

// >>> tb.sv
// Self-checking bench of the trigger, mask and shift control
`timescale 1ns/10ps
`include "dtm_consts.svh"
module tb;
  import dtm_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic pready, pslverr, rerr, shift_in_bit = 1'b0, shift_step = 1'b0, shift_out_bit;
  logic front_trigger_in, connector_trigger_zero, connector_trigger_one, backplane_trigger;
  logic [3:0] lvl = 4'h0, lv, p;
  logic front_open = 1'b0, capture_clk_run, stimulus_clk_run;
  dtm_word_type wi = 24'h0, ri = 24'h0, wo, ro, shift_word, m;
  logic [10:0] delay_capture, delay_stimulus, delay_connector, dv;
  logic [2:0] clock_source_select, cs;
  logic [3:0] revs [3] = '{4'h2, 4'h6, 4'h9};
  logic [63:0] bits;
  int fail_count = 0, checks = 0, cyc = 0, n, d, i;

  dtm_ctrl dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata), .front_trigger_in(front_trigger_in),
    .connector_trigger_zero(connector_trigger_zero), .connector_trigger_one(connector_trigger_one),
    .backplane_trigger(backplane_trigger), .mem_wr_data_in(wi), .mem_wr_data_out(wo), .mem_rd_data_in(ri),
    .mem_rd_data_out(ro), .shift_in_bit(shift_in_bit), .shift_step(shift_step), .shift_out_bit(shift_out_bit),
    .shift_word(shift_word), .capture_clk_run(capture_clk_run), .stimulus_clk_run(stimulus_clk_run),
    .delay_capture(delay_capture), .delay_stimulus(delay_stimulus), .delay_connector(delay_connector),
    .clock_source_select(clock_source_select));
  dtm_trig_model far (.clk(clk), .lvl(lvl), .front_open(front_open), .front_trigger_in(front_trigger_in),
    .connector_trigger_zero(connector_trigger_zero), .connector_trigger_one(connector_trigger_one),
    .backplane_trigger(backplane_trigger));

  // Clock and hang guard
  initial begin
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      fail_count++;
      conclude();
    end
  end

  task automatic conclude();
    if (fail_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One APB transfer: setup, access held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dat);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= dat;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata; rerr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] dat); apb(1'b1, a, dat); endtask
  task automatic rd(input logic [11:0] a); apb(1'b0, a, 32'h0); endtask
  // Expected source {active level, pin index}: 0 soft, 1 front, 2 zero, 3 one, 4 backplane
  function automatic logic [3:0] pick(input logic [3:0] rev, input logic hs, input int code, input logic pol);
    logic nine;
    nine = rev >= 4'h9;
    case (code)
      0: pick = 4'h0;
      1: pick = {rev >= 4'h5, 3'h1};
      2: pick = (nine && !hs) ? 4'hb : 4'ha;
      3: pick = (nine && !hs) ? {!pol, 3'h4} : 4'h3;
      default: pick = {!pol, 3'h4};
    endcase
  endfunction

  initial begin
    void'($urandom(32'had7f));
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    rd(`DTM_ADDR_MASK); chk("mask rst", 32'h00ffffff, rdat);
    rd(`DTM_ADDR_DEPTH); chk("depth rst", 32'h8, rdat);
    rd(`DTM_ADDR_SOFT); chk("soft rst", 32'h0, rdat);
    rd(12'h024); chk("unmapped err", 32'h1, 32'(rerr));
    // Keep mask on both memory paths, in either mode
    for (i = 0; i < 8; i++) begin
      m = (i == 0) ? 24'h0003ff : 24'($urandom);
      wr(`DTM_ADDR_MASK, 32'(m));
      wr(`DTM_ADDR_CTRL, 32'(i % 2));
      wi <= 24'($urandom); ri <= 24'($urandom);
      repeat (2) @(posedge clk);
      chk("mem wr", 32'(wi & m), 32'(wo));
      chk("mem rd", 32'(ri & m), 32'(ro));
    end
    wr(`DTM_ADDR_MASK, 32'h00ffffff);
    wr(`DTM_ADDR_CTRL, 32'h0);
    // Depth bounds, then shifting with the depth in use
    wr(`DTM_ADDR_DEPTH, 32'h0); rd(`DTM_ADDR_DEPTH); chk("depth 0", 32'h8, rdat);
    wr(`DTM_ADDR_DEPTH, 32'h19); rd(`DTM_ADDR_DEPTH); chk("depth 25", 32'h8, rdat);
    for (i = 0; i < 3; i++) begin
      d = (i == 0) ? 24 : (i == 1) ? 1 : 2 + $urandom % 22;
      wr(`DTM_ADDR_DEPTH, 32'(d)); rd(`DTM_ADDR_DEPTH); chk("depth", 32'(d), rdat);
      bits = {$urandom, $urandom};
      n = d + 3;
      for (int k = 0; k < n; k++) begin
        @(posedge clk);
        shift_step <= 1'b1; shift_in_bit <= bits[k];
      end
      @(posedge clk); shift_step <= 1'b0;
      repeat (2) @(posedge clk);
      chk("shift out", 32'(bits[n-d]), 32'(shift_out_bit));
      chk("shift unused", 32'h0, 32'(shift_word >> d));
    end
    // Delay lines: program, query, ports, refusals
    for (i = 0; i < 3; i++) begin
      dv = (i == 0) ? `DTM_DLY_MAX : 11'($urandom % 1842);
      wr(`DTM_ADDR_DLY_SEL, 32'(i)); wr(`DTM_ADDR_DLY_VAL, 32'(dv));
      wr(`DTM_ADDR_DLY_VAL, 32'h733); wr(`DTM_ADDR_DLY_SEL, 32'h3);
      rd(`DTM_ADDR_DLY_VAL); chk("delay query", 32'(dv), rdat);
      chk("delay port", 32'(dv), 32'(i == 0 ? delay_capture : i == 1 ? delay_stimulus : delay_connector));
    end
    // Every trigger code of every revision band and speed
    for (int r = 0; r < 3; r++) for (int hs = 0; hs < 2; hs++)
      for (int code = 0; code <= ((revs[r] >= 4'h9 && hs == 1) ? 4 : 3); code++) begin
        cs = 3'($urandom); m[0] = 1'(code);
        p = pick(revs[r], 1'(hs), code, m[0]);
        wr(`DTM_ADDR_CTRL, 32'h0); wr(`DTM_ADDR_SOFT, 32'h0); wr(`DTM_ADDR_REV, 32'(revs[r]));
        lv = 4'($urandom);
        if (p[2:0] != 3'h0) lv[p[2:0]-1] = !p[3];
        lvl <= lv; front_open <= 1'b0;
        wr(`DTM_ADDR_TRIG, {21'h0, cs, 5'h0, 3'(code)});
        wr(`DTM_ADDR_CTRL, {29'h0, m[0], 1'(hs), 1'b1});
        repeat (8) @(posedge clk);
        rd(`DTM_ADDR_STATUS); chk("armed", 32'h1, rdat & 32'h3);
        chk("run early", 32'h0, 32'(capture_clk_run));
        if (p[2:0] == 3'h0) wr(`DTM_ADDR_SOFT, 32'h1);
        else if (p == 4'h9 && code == 1 && r == 2) front_open <= 1'b1;
        else begin
          lv[p[2:0]-1] = p[3];
          lvl <= lv;
        end
        n = 0;
        do @(posedge clk); while (capture_clk_run !== 1'b1 && ++n < 20);
        chk("capture run", 32'h1, 32'(capture_clk_run));
        chk("stimulus run", 32'h1, 32'(stimulus_clk_run));
        chk("clock source", 32'(cs), 32'(clock_source_select));
        if (p[2:0] == 3'h0) begin
          rd(`DTM_ADDR_SOFT); chk("soft back", 32'h1, rdat);
        end
      end
    conclude();
  end
endmodule
